// file: hw/cam_fifo_pkg.sv
package cam_fifo_pkg;

    // ==========================================
    // sizes
    localparam int ENTRY_BITS    = 256;
    localparam int QUEUE_DEPTH   = 4;
    localparam int WORD_BITS     = 64;
    localparam int STATUS_BITS   = 32;
    localparam int MAX_DATA      = 3;
    localparam int DATA_CNT_BITS = 2;

    // ==========================================
    // status codes
    localparam logic [31:0] ST_SUCCESS      = 32'h0000_0000;
    localparam logic [31:0] ST_NOT_INIT     = 32'h0000_0003;
    localparam logic [31:0] ST_NOT_FOUND    = 32'h0000_000A;
    localparam logic [31:0] ST_NO_CONTEXT   = 32'h0000_000E;
    localparam logic [31:0] ST_HIER_BROKEN  = 32'h0000_0013;
    localparam logic [31:0] ST_EMPTY        = 32'h8000_0000;

    // ==========================================
    // engine numbers
    localparam logic [1:0] ENGINE_ONE = 2'h1;
    localparam logic [1:0] ENGINE_TWO = 2'h2;

    // ==========================================
    // reset values
    localparam logic [63:0] WORD_RESET = 64'h0000_0000_0000_0000;

    typedef enum logic [1:0]
    {
        CMD_REMOVE_PREFIX,
        CMD_REMOVE_EXACT,
        CMD_LOOKUP_EXACT,
        CMD_LOOKUP_PREFIX
    } command_t;

    // lookup outcome from the matching core
    typedef struct packed
    {
        logic        initialised;
        logic        has_context;
        logic        found;
        logic        hier_broken;
        logic [63:0] assoc_hi;
        logic [63:0] assoc_lo;
        logic [1:0]  assoc_words;
    } match_result_t;

    // one result entry: status plus up to three data words
    typedef struct packed
    {
        logic [1:0]   data_count;
        logic [29:0]  spare;
        logic [31:0]  status;
        logic [191:0] data;
    } result_entry_t;

endpackage : cam_fifo_pkg

// file: hw/result_ram.sv
`timescale 1ns/100ps

module result_ram #(
    parameter int WIDTH = 256,
    parameter int DEPTH = 4,
    parameter int AW    = 2
) (
    // clock
    input  wire logic             clock,
    // write side
    input  wire logic             wr_en,
    input  wire logic [AW-1:0]    wr_addr,
    input  wire logic [WIDTH-1:0] wr_data,
    // read side, registered
    input  wire logic [AW-1:0]    rd_addr,
    output logic      [WIDTH-1:0] rd_data
);

    logic [WIDTH-1:0] mem [DEPTH];

    always_ff @(posedge clock)
    begin
        if (wr_en)
            mem[wr_addr] <= wr_data;
        rd_data <= mem[rd_addr];
    end

endmodule : result_ram

// file: hw/cam_engine_command_result_fifo.sv
`timescale 1ns/100ps
// Summary of operation
// - status 0 success, 3 uninitialised, 14 nocontext
// - delete of absent key gives status 10
// - broken hierarchy 19 on exact seek only; plain miss 10, no data
// - successful seek carries association as data
// - empty status read returns 0x80000000, no pop
// - status read pops only data-less entries
// - data read of data-less entry returns status, pops
// - data reads step words, last pops entry
// - four command entries (opcodes only) and four result entries of 256 bits
// - range or parity error rings doorbell, warm reset

module cam_engine_command_result_fifo #(
    parameter int DEPTH = cam_fifo_pkg::QUEUE_DEPTH,
    parameter logic [1:0] ENGINE_ID = cam_fifo_pkg::ENGINE_ONE
) (
    // clock and reset
    input  wire logic                         clock,
    input  wire logic                         rstn,
    // command from host
    input  wire logic                         cmd_valid,
    input  wire logic [1:0]                   cmd_engine,
    input  wire cam_fifo_pkg::command_t       cmd_op,
    output logic                              cmd_ready,
    // lookup core
    output logic                              core_start,
    output cam_fifo_pkg::command_t            core_op,
    input  wire logic                         core_done,
    input  wire cam_fifo_pkg::match_result_t  core_result,
    // host reads of results
    input  wire logic                         read_oldest_result_status,
    input  wire logic                         read_result_word,
    output logic [31:0]                       status_out,
    output logic [63:0]                       word_out,
    output logic                              read_valid,
    // error traps
    input  wire logic                         range_violation,
    input  wire logic                         parity_error,
    output logic                              doorbell,
    output logic                              warm_reset
);

    localparam int AW = $clog2(DEPTH);

    // ==========================================
    // command queue (opcodes only; keys live in the core)
    cam_fifo_pkg::command_t cq [DEPTH];
    logic [AW:0]  cq_wr_reg;
    logic [AW:0]  cq_rd_reg;
    logic         busy_reg;
    logic [AW:0]  out_cnt_reg;
    logic         cmd_ready_reg;
    logic         core_start_reg;
    cam_fifo_pkg::command_t core_op_reg;

    wire logic cq_full   = (cq_wr_reg - cq_rd_reg) == (AW+1)'(DEPTH);
    wire logic cq_empty  = cq_wr_reg == cq_rd_reg;
    wire logic engine_ok = (cmd_engine == ENGINE_ID);
    wire logic cmd_take  = cmd_valid && engine_ok && cmd_ready_reg;
    // issue only when a result slot is reserved for it
    wire logic rq_room   = out_cnt_reg < (AW+1)'(DEPTH);
    wire logic issue     = !busy_reg && !cq_empty && rq_room;

    // ==========================================
    // result queue
    logic [AW:0]  rq_wr_reg;
    logic [AW:0]  rq_rd_reg;
    logic [1:0]   word_idx_reg;
    cam_fifo_pkg::result_entry_t head;
    cam_fifo_pkg::result_entry_t new_entry;

    function automatic logic [31:0] status_of(input cam_fifo_pkg::match_result_t r,
                                              input cam_fifo_pkg::command_t      op);
        if (!r.initialised)
            status_of = cam_fifo_pkg::ST_NOT_INIT;
        else if (!r.has_context)
            status_of = cam_fifo_pkg::ST_NO_CONTEXT;
        else if (r.hier_broken && op == cam_fifo_pkg::CMD_LOOKUP_EXACT)
            status_of = cam_fifo_pkg::ST_HIER_BROKEN;
        else if (!r.found)
            status_of = cam_fifo_pkg::ST_NOT_FOUND;
        else
            status_of = cam_fifo_pkg::ST_SUCCESS;
    endfunction : status_of

    wire logic [31:0] new_status = status_of(core_result, core_op_reg);
    wire logic is_seek = (core_op_reg == cam_fifo_pkg::CMD_LOOKUP_EXACT) ||
                         (core_op_reg == cam_fifo_pkg::CMD_LOOKUP_PREFIX);
    // association only on a successful seek
    wire logic [1:0] new_count = (is_seek && new_status == cam_fifo_pkg::ST_SUCCESS) ?
                                 core_result.assoc_words : 2'h0;

    assign new_entry.data_count = new_count;
    assign new_entry.spare      = 30'h0000_0000;
    assign new_entry.status     = new_status;
    assign new_entry.data       = {64'h0000_0000_0000_0000, core_result.assoc_hi, core_result.assoc_lo};

    wire logic rq_push  = busy_reg && core_done;
    wire logic rq_empty = rq_wr_reg == rq_rd_reg;
    logic ram_fresh_reg;
    wire logic head_ok  = !rq_empty && ram_fresh_reg;

    wire logic [63:0] head_word = (word_idx_reg == 2'h0) ? head.data[63:0] :
                                  (word_idx_reg == 2'h1) ? head.data[127:64] : head.data[191:128];
    wire logic has_data = head.data_count != 2'h0;
    wire logic last_word = (word_idx_reg + 2'h1) == head.data_count;
    // pop rules
    wire logic pop_stat = read_oldest_result_status && head_ok && !has_data;
    wire logic pop_data = read_result_word && head_ok && (!has_data || last_word);
    wire logic rq_pop   = pop_stat || pop_data;
    wire logic [AW:0] rq_rd_next = rq_pop ? rq_rd_reg + (AW+1)'(1) : rq_rd_reg;

    result_ram #(
        .WIDTH (cam_fifo_pkg::ENTRY_BITS),
        .DEPTH (DEPTH),
        .AW    (AW)
    ) u_result_ram (
        .clock   (clock),
        .wr_en   (rq_push),
        .wr_addr (rq_wr_reg[AW-1:0]),
        .wr_data (new_entry),
        .rd_addr (rq_rd_next[AW-1:0]),
        .rd_data (head)
    );

    // ==========================================
    // command side
    always_ff @(posedge clock)
    begin
        if (!rstn)
        begin
            cq_wr_reg      <= '0;
            cq_rd_reg      <= '0;
            busy_reg       <= 1'b0;
            out_cnt_reg    <= '0;
            cmd_ready_reg  <= 1'b0;
            core_start_reg <= 1'b0;
            core_op_reg    <= cam_fifo_pkg::CMD_REMOVE_PREFIX;
        end
        else
        begin
            if (cmd_take)
            begin
                cq[cq_wr_reg[AW-1:0]] <= cmd_op;
                cq_wr_reg <= cq_wr_reg + (AW+1)'(1);
            end
            cmd_ready_reg  <= !(cq_full || (cmd_take && (cq_wr_reg - cq_rd_reg) == (AW+1)'(DEPTH-1)))
                              || issue;
            core_start_reg <= issue;
            if (issue)
            begin
                core_op_reg <= cq[cq_rd_reg[AW-1:0]];
                cq_rd_reg   <= cq_rd_reg + (AW+1)'(1);
                busy_reg    <= 1'b1;
            end
            else if (rq_push)
                busy_reg <= 1'b0;
            out_cnt_reg <= out_cnt_reg + (AW+1)'(issue) - (AW+1)'(rq_pop);
        end
    end

    // ==========================================
    // result side
    always_ff @(posedge clock)
    begin
        if (!rstn)
        begin
            rq_wr_reg     <= '0;
            rq_rd_reg     <= '0;
            word_idx_reg  <= 2'h0;
            ram_fresh_reg <= 1'b0;
            status_out    <= cam_fifo_pkg::ST_EMPTY;
            word_out      <= cam_fifo_pkg::WORD_RESET;
            read_valid    <= 1'b0;
        end
        else
        begin
            if (rq_push)
                rq_wr_reg <= rq_wr_reg + (AW+1)'(1);
            rq_rd_reg     <= rq_rd_next;
            // ram output valid once a write to the head slot has settled
            ram_fresh_reg <= !(rq_push && rq_wr_reg[AW-1:0] == rq_rd_next[AW-1:0]);
            read_valid    <= read_oldest_result_status || read_result_word;
            if (rq_pop)
                word_idx_reg <= 2'h0;
            else if (read_result_word && head_ok && has_data)
                word_idx_reg <= word_idx_reg + 2'h1;
            if (read_oldest_result_status)
                status_out <= head_ok ? head.status : cam_fifo_pkg::ST_EMPTY;
            if (read_result_word)
                word_out <= !head_ok ? {32'h0000_0000, cam_fifo_pkg::ST_EMPTY} :
                            has_data ? head_word : {32'h0000_0000, head.status};
        end
    end

    // ==========================================
    // error traps
    always_ff @(posedge clock)
    begin
        if (!rstn)
        begin
            doorbell   <= 1'b0;
            warm_reset <= 1'b0;
        end
        else
        begin
            doorbell <= range_violation || parity_error;
            if (range_violation || parity_error)
                warm_reset <= 1'b1;
        end
    end

    assign cmd_ready  = cmd_ready_reg;
    assign core_start = core_start_reg;
    assign core_op    = core_op_reg;

endmodule : cam_engine_command_result_fifo

// file: tb/cam_fifo_assertions.sv
`timescale 1ns/100ps
module cam_fifo_assertions (
    // clock and reset
    input wire logic        clock,
    input wire logic        rstn,
    // core side
    input wire logic        core_start,
    input wire logic        core_done,
    // host reads
    input wire logic        read_oldest_result_status,
    input wire logic        read_result_word,
    input wire logic [31:0] status_out,
    input wire logic [63:0] word_out,
    input wire logic        read_valid,
    // traps
    input wire logic        range_violation,
    input wire logic        parity_error,
    input wire logic        doorbell,
    input wire logic        warm_reset
);
    // ==========================================
    // properties
    default clocking @(posedge clock); endclocking
    default disable iff (!rstn);
    wire logic rd_any = read_oldest_result_status | read_result_word;
    wire logic trap   = range_violation | parity_error;
    read_answer_a: assert property (rd_any |=> read_valid)
        else $error("read strobe got no answer");
    read_quiet_a: assert property (!rd_any |=> !read_valid)
        else $error("answer without a read strobe");
    status_hold_a: assert property (!read_oldest_result_status |=> $stable(status_out))
        else $error("status moved without a status read");
    word_hold_a: assert property (!read_result_word |=> $stable(word_out))
        else $error("word moved without a word read");
    issue_single_a: assert property (core_start |=> !core_start)
        else $error("two core issues back to back");
    trap_bell_a: assert property (trap |-> ##[1:2] doorbell)
        else $error("trap rang no doorbell");
    warm_cause_a: assert property ($rose(warm_reset) |-> $past(trap) || $past(trap, 2))
        else $error("warm reset without a trap");
    warm_sticky_a: assert property (warm_reset |=> warm_reset)
        else $error("warm reset dropped");
    cover property (core_done);
    cover property (read_valid && status_out == cam_fifo_pkg::ST_EMPTY);
    cover property ($rose(warm_reset));
endmodule : cam_fifo_assertions

bind cam_engine_command_result_fifo cam_fifo_assertions i_cam_fifo_assertions (.clock, .rstn, .core_start,
    .core_done, .read_oldest_result_status, .read_result_word, .status_out, .word_out, .read_valid,
    .range_violation, .parity_error, .doorbell, .warm_reset);

// file: tb/core_model.sv
`timescale 1ns/100ps
module core_model (
    // clock and reset
    input  wire logic                   clock,
    input  wire logic                   rstn,
    // core handshake
    input  wire logic                   core_start,
    input  wire logic                   slow,
    output logic                        core_done,
    output cam_fifo_pkg::match_result_t core_result
);
    cam_fifo_pkg::match_result_t res_q[$];
    cam_fifo_pkg::match_result_t res_reg  = '0;
    logic [3:0]                  wait_reg = 4'h0;
    logic                        busy_reg = 1'b0;
    task automatic push(input cam_fifo_pkg::match_result_t r);
        res_q.push_back(r);
    endtask : push
    // result lines carry garbage outside the done pulse
    assign core_result = core_done ? res_reg : ~res_reg;
    always @(posedge clock)
    begin
        core_done <= 1'b0;
        if (!rstn)
            busy_reg <= 1'b0;
        else if (core_start)
        begin
            busy_reg <= 1'b1;
            wait_reg <= slow ? 4'h7 : 4'h0;
        end
        else if (busy_reg && wait_reg != 4'h0)
            wait_reg <= wait_reg - 4'h1;
        else if (busy_reg && res_q.size() != 0)
        begin
            res_reg   <= res_q.pop_front();
            core_done <= 1'b1;
            busy_reg  <= 1'b0;
        end
    end
endmodule : core_model

// file: tb/testbench.sv
`timescale 1ns/100ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin fails++; \
    $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module testbench;
    logic        clock, rstn, cmd_valid, cmd_ready, core_start, core_done, slow;
    logic        read_oldest_result_status, read_result_word, read_valid;
    logic        range_violation, parity_error, doorbell, warm_reset;
    logic [1:0]  cmd_engine;
    logic [31:0] status_out;
    logic [63:0] word_out, lo_v, hi_v;
    logic [65:0] exp_q[$], e;
    logic [63:0] key_w [4];
    logic [31:0] prefix_value;
    logic [6:0]  group_id;
    logic [5:0]  prefix_length;
    cam_fifo_pkg::command_t      cmd_op, core_op;
    cam_fifo_pkg::command_t      op_q[$], op_e;
    cam_fifo_pkg::match_result_t core_result;
    int          fails, comparisons, cycles, issued, done_cnt;
    integer      seed = 32'hac41_8000;

    cam_engine_command_result_fifo i_cam_engine_command_result_fifo (.clock, .rstn, .cmd_valid, .cmd_engine,
        .cmd_op, .cmd_ready, .core_start, .core_op, .core_done, .core_result, .read_oldest_result_status,
        .read_result_word, .status_out, .word_out, .read_valid, .range_violation, .parity_error, .doorbell,
        .warm_reset);
    core_model i_core_model (.clock, .rstn, .core_start, .slow, .core_done, .core_result);

    initial
    begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end

    always @(posedge clock)
    begin
        cycles++;
        if (core_done === 1'b1)
            done_cnt++;
        if (cycles == 3000)
        begin
            fails++;
            give_verdict();
        end
    end

    // ==========================================
    // monitor: oldest note against each answer
    always @(negedge clock)
    begin
        if (core_start === 1'b1 && op_q.size() == 0)
            `CHK(core_start, 1'b0)
        else if (core_start === 1'b1)
        begin
            op_e = op_q.pop_front();
            `CHK(core_op, op_e)
        end
        if (read_valid === 1'b1 && exp_q.size() == 0)
            `CHK(read_valid, 1'b0)
        else if (read_valid === 1'b1)
        begin
            e = exp_q.pop_front();
            if (e[65:64] == 2'h0) `CHK(status_out, e[31:0])
            else if (e[65:64] == 2'h1) `CHK(word_out, e[63:0])
            else `CHK(word_out[31:0], e[31:0])
        end
    end

    task automatic give_verdict();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : give_verdict

    task automatic cmd(input cam_fifo_pkg::command_t op, input logic [3:0] f, input logic [1:0] eng);
        if (eng == cam_fifo_pkg::ENGINE_ONE)
        begin
            i_core_model.push('{f[3], f[2], f[1], f[0], hi_v, lo_v, 2'h2});
            op_q.push_back(op);
            issued++;
        end
        while (cmd_ready !== 1'b1)
            @(negedge clock);
        @(posedge clock);
        cmd_valid  <= 1'b1;
        cmd_op     <= op;
        cmd_engine <= eng;
        @(posedge clock);
        cmd_valid <= 1'b0;
    endtask : cmd

    task automatic rd(input logic [1:0] kind, input logic [63:0] x);
        exp_q.push_back({kind, x});
        @(posedge clock);
        if (kind == 2'h0)
            read_oldest_result_status <= 1'b1;
        else
            read_result_word <= 1'b1;
        @(posedge clock);
        read_oldest_result_status <= 1'b0;
        read_result_word          <= 1'b0;
    endtask : rd

    task automatic settle();
        wait (done_cnt == issued);
        repeat (3) @(posedge clock);
    endtask : settle

    // ==========================================
    // main sequence
    initial
    begin
        {rstn, cmd_valid, read_oldest_result_status, read_result_word, range_violation, parity_error, slow} = '0;
        cmd_engine = cam_fifo_pkg::ENGINE_ONE;
        cmd_op = cam_fifo_pkg::CMD_REMOVE_PREFIX;
        // host key forms: words from element zero, leftover bytes low, prefix left aligned
        key_w[0]      = {$random(seed), $random(seed)};
        key_w[1]      = {48'h0000_0000_0000, 16'($random(seed))};
        key_w[2]      = 64'h0000_0000_0000_0000;
        key_w[3]      = 64'h0000_0000_0000_0000;
        prefix_length = 6'h18;
        prefix_value  = $random(seed) & ~(32'hffff_ffff >> prefix_length);
        group_id      = 7'($random(seed));
        lo_v          = key_w[0] ^ key_w[1] ^ key_w[2] ^ key_w[3];
        hi_v          = {prefix_value, 19'h0_0000, group_id, prefix_length};
        repeat (3) @(posedge clock);
        rstn <= 1'b1;
        repeat (2) @(posedge clock);
        `CHK(cmd_ready, 1'b1)
        rd(2'h0, 64'h8000_0000);
        rd(2'h2, 64'h8000_0000);
        cmd(cam_fifo_pkg::CMD_LOOKUP_EXACT, 4'hE, cam_fifo_pkg::ENGINE_TWO);
        repeat (12) @(posedge clock);
        rd(2'h0, 64'h8000_0000);
        // three ahead, read back in order
        cmd(cam_fifo_pkg::CMD_REMOVE_PREFIX, 4'h6, cam_fifo_pkg::ENGINE_ONE);
        cmd(cam_fifo_pkg::CMD_LOOKUP_PREFIX, 4'hA, cam_fifo_pkg::ENGINE_ONE);
        cmd(cam_fifo_pkg::CMD_LOOKUP_EXACT, 4'hD, cam_fifo_pkg::ENGINE_ONE);
        settle();
        rd(2'h0, 64'h3);
        rd(2'h0, 64'hE);
        rd(2'h0, 64'h13);
        slow <= 1'b1;
        cmd(cam_fifo_pkg::CMD_REMOVE_EXACT, 4'hC, cam_fifo_pkg::ENGINE_ONE);
        cmd(cam_fifo_pkg::CMD_LOOKUP_PREFIX, 4'hC, cam_fifo_pkg::ENGINE_ONE);
        cmd(cam_fifo_pkg::CMD_LOOKUP_EXACT, 4'hE, cam_fifo_pkg::ENGINE_ONE);
        settle();
        rd(2'h0, 64'hA);
        rd(2'h2, 64'hA);
        rd(2'h0, 64'h0);
        rd(2'h0, 64'h0);
        rd(2'h1, lo_v);
        rd(2'h1, hi_v);
        rd(2'h0, 64'h8000_0000);
        cmd(cam_fifo_pkg::CMD_REMOVE_PREFIX, 4'hE, cam_fifo_pkg::ENGINE_ONE);
        settle();
        rd(2'h2, 64'h0);
        rd(2'h0, 64'h8000_0000);
        // traps
        range_violation <= 1'b1;
        @(posedge clock);
        range_violation <= 1'b0;
        @(negedge clock);
        `CHK(doorbell, 1'b1)
        repeat (3) @(posedge clock);
        `CHK(warm_reset, 1'b1)
        rstn <= 1'b0;
        repeat (3) @(posedge clock);
        `CHK(warm_reset, 1'b0)
        rstn         <= 1'b1;
        parity_error <= 1'b1;
        @(posedge clock);
        parity_error <= 1'b0;
        @(negedge clock);
        `CHK(doorbell, 1'b1)
        repeat (3) @(posedge clock);
        `CHK(warm_reset, 1'b1)
        give_verdict();
    end
endmodule : testbench
